// ---- include/ssc_pkg.sv ----
`default_nettype none
package ssc_pkg;
    // Reload field width; the largest divider is 2**13 = 8192
    localparam int SSC_RELOAD_W = 13;
    // Clocks per oversample tick before the reload divider; 16 ticks per bit gives /32 or /48
    localparam logic [1:0] SSC_PRE_LO = 2'h2;
    localparam logic [1:0] SSC_PRE_HI = 2'h3;
    // Tick phases within one bit time of 16 ticks
    localparam logic [3:0] SSC_PH_MID = 4'h7;
    localparam logic [3:0] SSC_PH_RISE = 4'h8;
    localparam logic [3:0] SSC_PH_LAST = 4'hf;
    // Bit counts
    localparam logic [3:0] SSC_BITS8 = 4'h8;
    localparam logic [3:0] SSC_BITS9 = 4'h9;
    localparam logic [3:0] SSC_FRAME8 = 4'ha;
    localparam logic [3:0] SSC_ONE = 4'h1;

    typedef enum logic [1:0] {SSC_M_SYNC, SSC_M_ASYNC8, SSC_M_ASYNC9, SSC_M_WAKE} ssc_mode_t;
    typedef enum logic {SSC_TX_IDLE, SSC_TX_SHIFT} ssc_tx_st_t;
    typedef enum logic [1:0] {SSC_RX_IDLE, SSC_RX_START, SSC_RX_BITS} ssc_rx_st_t;
endpackage : ssc_pkg
`default_nettype wire

// ---- rtl/ssc_baud_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssc_baud_gen
    import ssc_pkg::*;
#(
    parameter int RW = SSC_RELOAD_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic baud_prescale_select,
    input wire logic [RW-1:0] reload,
    output var logic tick
);
    logic [1:0] pre_cnt_reg;
    logic [RW-1:0] div_cnt_reg;
    logic [1:0] pre_top;

    assign pre_top = (baud_prescale_select ? SSC_PRE_HI : SSC_PRE_LO) - 2'h1;

    // Free of any oscillator trimming: the bit rate is purely a divide of the CPU clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_reg <= 2'h0;
            div_cnt_reg <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            pre_cnt_reg <= 2'h0;
            div_cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (pre_cnt_reg >= pre_top) begin
                pre_cnt_reg <= 2'h0;
                // A divider lowered mid-count must wrap at once, not run round the whole 13-bit range
                if (div_cnt_reg >= reload) begin
                    div_cnt_reg <= '0;
                    tick <= 1'b1;
                end else begin
                    div_cnt_reg <= div_cnt_reg + {{(RW - 1){1'b0}}, 1'b1};
                end
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 2'h1;
            end
        end
    end

    tick_gap_a: assert property (@(posedge clock) disable iff (!rst_n) tick |=> !tick)
        else $error("baud ticks closer than the prescaler allows");
endmodule : ssc_baud_gen
`default_nettype wire

// ---- rtl/ssc_vote.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssc_vote (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic din,
    output logic vote
);
    logic [2:0] hist_reg;

    // Three samples one tick apart; a single glitch cannot flip a bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hist_reg <= 3'h7;
        end else if (tick) begin
            hist_reg <= {hist_reg[1:0], din};
        end
    end

    assign vote = (hist_reg[0] & hist_reg[1]) | (hist_reg[0] & hist_reg[2]) | (hist_reg[1] & hist_reg[2]);
endmodule : ssc_vote
`default_nettype wire

// ---- rtl/ssc_serial_channel.sv ----
// Behaviour
// - A baud generator of the channel's own divides the CPU clock to the bit rate, with no oscillator tuning.
// - Three separate interrupt requests are raised: transmit done, receive done and receive error.
// - Async frames are one start bit, 8 or 9 data bits and one or two stop bits as configured.
// - The wake-up format carries 8 data bits plus a wake bit that marks address bytes.
// - Sync mode shifts whole bytes on a shift clock that this channel generates and drives.
// - Characters are always shifted least significant bit first.
// - A loopback option routes the transmit stream back into the receiver.
// - In 8-bit async mode with parity on, a parity bit is appended on transmit and checked on receive, flagging a mismatch.
// - With framing checks on, a missing stop bit is reported as a framing error.
// - With overrun checks on, a character completing while the last one is unread is an overrun.
// - Reload zero at 50 MHz gives 1562500 baud with prescale select clear and 1041666 baud with it set.
`timescale 1ns/100ps
`default_nettype none
module ssc_serial_channel
    import ssc_pkg::*;
#(
    parameter int RW = SSC_RELOAD_W
) (
    input wire logic clock,
    input wire logic nrst,
    input wire ssc_mode_t mode,
    input wire logic run,
    input wire logic rx_enable,
    input wire logic stop2,
    input wire logic parity_en,
    input wire logic parity_odd,
    input wire logic frame_chk_en,
    input wire logic overrun_chk_en,
    input wire logic loopback,
    input wire logic baud_prescale_select,
    input wire logic [RW-1:0] baud_reload,
    input wire logic [8:0] tx_data,
    input wire logic tx_write,
    input wire logic sync_rx_start,
    input wire logic rx_read,
    input wire logic err_clear,
    input wire logic serial_rx_in,
    output logic serial_txd,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    output logic [8:0] rx_data,
    output logic rx_full,
    output logic tx_busy,
    output logic tx_irq,
    output logic rx_irq,
    output logic err_irq,
    output logic parity_err,
    output logic frame_err,
    output logic overrun_err
);
    logic rst_meta_reg, rst_n_reg, rst_n;
    logic tick, rx_in, rx_vote;
    ssc_tx_st_t tx_st_reg;
    ssc_rx_st_t rx_st_reg;
    logic [11:0] tx_sh_reg;
    logic [3:0] tx_left_reg, tx_ph_reg, rx_ph_reg, rx_idx_reg;
    logic sync_rx_reg;
    logic [8:0] rx_sh_reg, rx_data_reg, rx_word, sync_word;
    logic serial_txd_reg, serial_data_out_reg, serial_data_oe_n_reg;
    logic rx_full_reg, tx_irq_reg, rx_irq_reg, err_irq_reg;
    logic parity_err_reg, frame_err_reg, overrun_err_reg;
    logic is_sync, ninth_en, par_mode, ninth_val, tx_par, tx_go, srx_go, tx_end;
    logic sync_cap, sync_done, sclk, tx_line, sync_drive;
    logic rx_active, rx_stop, rx_bit, rx_start_ev, deliver, par_bad, frame_bad, ovr_hit;
    logic [3:0] rx_total, tx_frame_len;

    // Release of the external reset is retimed so no flop leaves reset on a ragged edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_n_reg;

    ssc_baud_gen #(.RW(RW)) u_baud (
        .clock(clock),
        .rst_n(rst_n),
        .run(run),
        .baud_prescale_select(baud_prescale_select),
        .reload(baud_reload),
        .tick(tick)
    );

    // Looped data is taken from the registered pins, so the loop sees what the line would see
    assign rx_in = !loopback ? serial_rx_in : (is_sync ? serial_data_out_reg : serial_txd_reg);

    ssc_vote u_vote (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick),
        .din(rx_in),
        .vote(rx_vote)
    );

    assign is_sync = (mode == SSC_M_SYNC);
    assign par_mode = (mode == SSC_M_ASYNC8) && parity_en;
    assign ninth_en = (mode == SSC_M_ASYNC9) || (mode == SSC_M_WAKE) || par_mode;
    assign tx_par = (^tx_data[7:0]) ^ parity_odd;
    assign ninth_val = par_mode ? tx_par : tx_data[8];
    assign tx_frame_len = SSC_FRAME8 + {3'h0, ninth_en} + {3'h0, stop2};
    assign rx_total = ninth_en ? SSC_BITS9 : SSC_BITS8;

    // A write while busy is dropped; software watches tx_busy
    assign tx_go = run && tx_write && (tx_st_reg == SSC_TX_IDLE);
    assign srx_go = run && is_sync && rx_enable && sync_rx_start && !tx_write && (tx_st_reg == SSC_TX_IDLE);
    assign tx_end = run && tick && (tx_st_reg == SSC_TX_SHIFT) && (tx_ph_reg == SSC_PH_LAST)
        && (tx_left_reg == SSC_ONE);
    assign sync_cap = run && tick && is_sync && (tx_st_reg == SSC_TX_SHIFT) && (tx_ph_reg == SSC_PH_LAST);
    assign sync_done = tx_end && is_sync && (sync_rx_reg || loopback);
    assign sync_word = {1'b0, rx_in, rx_sh_reg[7:1]};
    assign sclk = (tx_st_reg == SSC_TX_SHIFT) ? (tx_ph_reg >= SSC_PH_RISE) : 1'b1;
    assign tx_line = (tx_st_reg == SSC_TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
    assign sync_drive = is_sync && (tx_st_reg == SSC_TX_SHIFT) && !sync_rx_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_reg <= SSC_TX_IDLE;
            tx_sh_reg <= 12'hfff;
            tx_left_reg <= 4'h0;
            tx_ph_reg <= 4'h0;
            sync_rx_reg <= 1'b0;
        end else begin
            unique case (tx_st_reg)
                SSC_TX_IDLE: begin
                    tx_ph_reg <= 4'h0;
                    if (tx_go) begin
                        tx_st_reg <= SSC_TX_SHIFT;
                        sync_rx_reg <= 1'b0;
                        if (is_sync) begin
                            tx_sh_reg <= {4'hf, tx_data[7:0]};
                            tx_left_reg <= SSC_BITS8;
                        end else begin
                            tx_sh_reg <= {2'b11, ninth_en ? ninth_val : 1'b1, tx_data[7:0], 1'b0};
                            tx_left_reg <= tx_frame_len;
                        end
                    end else if (srx_go) begin
                        tx_st_reg <= SSC_TX_SHIFT;
                        sync_rx_reg <= 1'b1;
                        tx_sh_reg <= 12'hfff;
                        tx_left_reg <= SSC_BITS8;
                    end
                end
                SSC_TX_SHIFT: begin
                    if (!run) begin
                        tx_st_reg <= SSC_TX_IDLE;
                    end else if (tick) begin
                        tx_ph_reg <= tx_ph_reg + 4'h1;
                        if (tx_ph_reg == SSC_PH_LAST) begin
                            tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
                            tx_left_reg <= tx_left_reg - 4'h1;
                            if (tx_left_reg == SSC_ONE) begin
                                tx_st_reg <= SSC_TX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // In sync mode the clock pin carries the shift clock and the data pin turns around for receive
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_txd_reg <= 1'b1;
            serial_data_out_reg <= 1'b1;
            serial_data_oe_n_reg <= 1'b1;
        end else begin
            serial_txd_reg <= is_sync ? sclk : tx_line;
            serial_data_out_reg <= sync_drive ? tx_sh_reg[0] : 1'b1;
            serial_data_oe_n_reg <= !sync_drive;
        end
    end

    assign rx_active = run && rx_enable && !is_sync;
    assign rx_start_ev = rx_active && tick && (rx_st_reg == SSC_RX_IDLE) && !rx_in;
    assign rx_bit = rx_active && tick && (rx_st_reg == SSC_RX_BITS) && (rx_ph_reg == SSC_PH_MID)
        && (rx_idx_reg != rx_total);
    assign rx_stop = rx_active && tick && (rx_st_reg == SSC_RX_BITS) && (rx_ph_reg == SSC_PH_MID)
        && (rx_idx_reg == rx_total);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_reg <= SSC_RX_IDLE;
            rx_ph_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
        end else if (!rx_active) begin
            rx_st_reg <= SSC_RX_IDLE;
        end else if (tick) begin
            unique case (rx_st_reg)
                SSC_RX_IDLE: begin
                    rx_ph_reg <= 4'h0;
                    if (!rx_in) begin
                        rx_st_reg <= SSC_RX_START;
                    end
                end
                SSC_RX_START: begin
                    rx_ph_reg <= rx_ph_reg + 4'h1;
                    if (rx_ph_reg == SSC_PH_MID && rx_vote) begin
                        // A short low pulse is noise, not a start bit
                        rx_st_reg <= SSC_RX_IDLE;
                    end else if (rx_ph_reg == SSC_PH_LAST) begin
                        rx_st_reg <= SSC_RX_BITS;
                        rx_idx_reg <= 4'h0;
                    end
                end
                SSC_RX_BITS: begin
                    rx_ph_reg <= rx_ph_reg + 4'h1;
                    if (rx_ph_reg == SSC_PH_MID) begin
                        // Leave at mid stop bit so the next start edge is caught early
                        if (rx_idx_reg == rx_total) begin
                            rx_st_reg <= SSC_RX_IDLE;
                        end else begin
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    rx_st_reg <= SSC_RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_reg <= 9'h000;
        end else if (rx_start_ev) begin
            rx_sh_reg <= 9'h000;
        end else if (rx_bit) begin
            rx_sh_reg[rx_idx_reg] <= rx_vote;
        end else if (sync_cap) begin
            rx_sh_reg <= sync_word;
        end
    end

    // A wake-mode frame with the wake bit clear is not for this node and is dropped
    assign deliver = (rx_stop && !((mode == SSC_M_WAKE) && !rx_sh_reg[8])) || sync_done;
    assign rx_word = is_sync ? sync_word : (par_mode ? {1'b0, rx_sh_reg[7:0]} : rx_sh_reg);
    assign par_bad = rx_stop && par_mode && (((^rx_sh_reg[7:0]) ^ parity_odd) != rx_sh_reg[8]);
    assign frame_bad = rx_stop && frame_chk_en && !rx_vote;
    assign ovr_hit = deliver && rx_full_reg && overrun_chk_en;

    // Hardware sets win over software clears arriving in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_reg <= 9'h000;
            rx_full_reg <= 1'b0;
        end else begin
            if (deliver) begin
                rx_data_reg <= rx_word;
            end
            if (deliver) begin
                rx_full_reg <= 1'b1;
            end else if (rx_read) begin
                rx_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            parity_err_reg <= 1'b0;
            frame_err_reg <= 1'b0;
            overrun_err_reg <= 1'b0;
        end else begin
            parity_err_reg <= par_bad || (parity_err_reg && !err_clear);
            frame_err_reg <= frame_bad || (frame_err_reg && !err_clear);
            overrun_err_reg <= ovr_hit || (overrun_err_reg && !err_clear);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_irq_reg <= 1'b0;
            rx_irq_reg <= 1'b0;
            err_irq_reg <= 1'b0;
        end else begin
            tx_irq_reg <= tx_end && !sync_rx_reg;
            rx_irq_reg <= deliver;
            err_irq_reg <= par_bad || frame_bad || ovr_hit;
        end
    end

    assign serial_txd = serial_txd_reg;
    assign serial_data_out = serial_data_out_reg;
    assign serial_data_oe_n = serial_data_oe_n_reg;
    assign rx_data = rx_data_reg;
    assign rx_full = rx_full_reg;
    assign tx_busy = (tx_st_reg == SSC_TX_SHIFT);
    assign tx_irq = tx_irq_reg;
    assign rx_irq = rx_irq_reg;
    assign err_irq = err_irq_reg;
    assign parity_err = parity_err_reg;
    assign frame_err = frame_err_reg;
    assign overrun_err = overrun_err_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence async_load_s;
        tx_go && !is_sync;
    endsequence
    sequence sync_rise_s;
        is_sync && tick && run && (tx_st_reg == SSC_TX_SHIFT) && (tx_ph_reg == SSC_PH_MID);
    endsequence

    start_bit_a: assert property (async_load_s |-> ##2 !serial_txd_reg)
        else $error("async frame did not open with a low start bit");
    stop_bits_a: assert property ((tx_st_reg == SSC_TX_SHIFT) && !is_sync
        && (tx_left_reg <= {3'h0, stop2} + SSC_ONE) |-> tx_sh_reg[0])
        else $error("stop bit slot not high");
    lsb_first_a: assert property (async_load_s |=> tx_sh_reg[1] == $past(tx_data[0]))
        else $error("first data bit is not the lsb");
    parity_gen_a: assert property (async_load_s ##0 par_mode |=> tx_sh_reg[9] == $past(tx_par))
        else $error("wrong parity bit queued");
    sync_clock_a: assert property (sync_rise_s |-> ##2 serial_txd_reg)
        else $error("shift clock not high in second half of bit");
    loopback_a: assert property (loopback && !is_sync && tick |=> u_vote.hist_reg[0] == $past(serial_txd_reg))
        else $error("loopback not fed from transmit line");
    frame_err_a: assert property (frame_bad |=> frame_err_reg && err_irq_reg)
        else $error("missing stop bit not flagged");
    overrun_a: assert property (ovr_hit |=> overrun_err_reg && rx_full_reg && err_irq_reg)
        else $error("overrun not flagged");
    rx_irq_a: assert property (deliver |=> rx_irq_reg && rx_data_reg == $past(rx_word))
        else $error("receive request without its character");
endmodule : ssc_serial_channel
`default_nettype wire

// ---- tb/ssc_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssc_peer (
    input wire logic clock,
    input wire logic txd,
    input wire logic dout,
    output logic rxd
);
    initial rxd = 1'b1;

    // Async frame, first list entry first; the line rests high afterwards
    task automatic send(input logic [11:0] bits, input int n, input int blen);
        for (int i = 0; i < n; i++) begin
            rxd = bits[i];
            repeat (blen) @(negedge clock);
        end
        rxd = 1'b1;
    endtask : send

    // Samples mid-bit from the start edge and times the first high run after the start bit;
    // the start bit may be cut short by the free-running tick, so it cannot show the bit time
    task automatic recv(input int n, input int blen, output logic [11:0] bits, output int run_len);
        int k;
        int rise_k;
        bits = '1;
        run_len = 0;
        rise_k = -1;
        k = 0;
        while (txd !== 1'b0 && k < 4000) begin
            @(negedge clock);
            k++;
        end
        for (k = 0; k < n * blen; k++) begin
            if (k % blen == blen / 2) bits[k / blen] = txd;
            if (txd === 1'b1 && rise_k < 0) rise_k = k;
            if (txd === 1'b0 && rise_k >= 0 && run_len == 0) run_len = k - rise_k;
            @(negedge clock);
        end
    endtask : recv

    // Drives a new bit on each falling shift clock, samples on each rising one
    task automatic shift(input logic [7:0] out_b, input int blen, output logic [7:0] in_b);
        logic prev;
        int i;
        prev = txd;
        i = 0;
        in_b = '0;
        for (int k = 0; k < 16 * blen && i < 8; k++) begin
            @(negedge clock);
            if (prev === 1'b1 && txd === 1'b0) rxd = out_b[i];
            if (prev === 1'b0 && txd === 1'b1) begin
                in_b[i] = dout;
                i++;
            end
            prev = txd;
        end
        // Hold the last bit past the device's sample point, then let the line wander
        repeat (blen / 2 + 2) @(negedge clock);
        rxd = ~rxd;
    endtask : shift
endmodule : ssc_peer
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ssc_pkg::*;
    localparam int BL = 32;
    logic clock, nrst, run, rx_enable, stop2, parity_en, parity_odd, frame_chk_en, overrun_chk_en;
    logic loopback, baud_prescale_select, tx_write, sync_rx_start, rx_read, err_clear, serial_rx_in;
    logic serial_txd, serial_data_out, serial_data_oe_n, rx_full, tx_busy, tx_irq, rx_irq, err_irq;
    logic parity_err, frame_err, overrun_err;
    ssc_mode_t mode;
    logic [12:0] baud_reload;
    logic [8:0] tx_data, rx_data;
    logic [2:0] irqs;
    logic [11:0] bits;
    logic [7:0] sb;
    int low;
    int failures = 0;
    int samples_checked = 0;
    assign irqs = {err_irq, rx_irq, tx_irq};

    ssc_serial_channel i_dut (.clock, .nrst, .mode, .run, .rx_enable, .stop2, .parity_en, .parity_odd,
        .frame_chk_en, .overrun_chk_en, .loopback, .baud_prescale_select, .baud_reload, .tx_data,
        .tx_write, .sync_rx_start, .rx_read, .err_clear, .serial_rx_in, .serial_txd, .serial_data_out,
        .serial_data_oe_n, .rx_data, .rx_full, .tx_busy, .tx_irq, .rx_irq, .err_irq, .parity_err,
        .frame_err, .overrun_err);
    ssc_peer i_peer (.clock(clock), .txd(serial_txd), .dout(serial_data_out), .rxd(serial_rx_in));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic check_n(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_n

    task automatic wait_irq(input int idx);
        for (int i = 0; i < 3000; i++) begin
            @(negedge clock);
            if (irqs[idx] === 1'b1) return;
        end
        check(12'h0, 12'h1);
        test_done();
    endtask : wait_irq

    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask : pulse

    task automatic send_tx(input logic [8:0] d);
        @(negedge clock);
        tx_data = d;
        tx_write = 1'b1;
        @(negedge clock);
        tx_write = 1'b0;
        check(tx_busy, 1'b1);
    endtask : send_tx

    task automatic clr;
        pulse(rx_read);
        pulse(err_clear);
        @(negedge clock);
        check({rx_full, overrun_err, frame_err, parity_err}, 4'h0);
    endtask : clr

    function automatic logic [11:0] frm(input logic [8:0] d, input int nd);
        frm = 12'hfff;
        for (int i = 0; i < nd; i++) frm[i + 1] = d[i];
        frm[0] = 1'b0;
    endfunction : frm

    // Transmit one char; compare the line bits, the first high run of runs bit times and the completion pulse
    task automatic tx_frame(input logic [8:0] d, input int n, input int blen, input int runs,
        input logic [11:0] exp);
        fork
            send_tx(d);
            i_peer.recv(n, blen, bits, low);
            wait_irq(0);
        join
        check(bits, exp);
        check_n(low, blen * runs);
        check(tx_busy, 1'b0);
    endtask : tx_frame

    task automatic rx_frame(input logic [11:0] f, input int n, input logic [8:0] exp_d, input logic [2:0] exp_e);
        fork
            i_peer.send(f, n, BL);
            begin
                wait_irq(1);
                check(err_irq, |exp_e);
                check(rx_data, exp_d);
                check({overrun_err, frame_err, parity_err}, exp_e);
                check(rx_full, 1'b1);
            end
        join
    endtask : rx_frame

    initial begin
        nrst = 1'b0;
        mode = SSC_M_ASYNC8;
        {run, rx_enable, stop2, parity_en, parity_odd, frame_chk_en, overrun_chk_en} = 7'h00;
        {loopback, baud_prescale_select, tx_write, sync_rx_start, rx_read, err_clear} = 6'h00;
        baud_reload = 13'h0000;
        tx_data = 9'h000;
        repeat (6) @(negedge clock);
        check({serial_txd, serial_data_out, serial_data_oe_n}, 3'h7);
        check({3'h0, rx_data}, 12'h000);
        check({7'h00, rx_full, tx_busy, irqs}, 12'h000);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        run = 1'b1;
        rx_enable = 1'b1;
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            for (int r = 0; r < 3; r += 2) begin
                baud_prescale_select = s[0];
                baud_reload = 13'(r);
                tx_frame(9'h0fd, 10, (s == 1 ? 48 : 32) * (r + 1), 1, frm(9'h0fd, 8));
            end
        end
        baud_prescale_select = 1'b0;
        baud_reload = 13'h0000;
        $display("test baud done");
        mode = SSC_M_ASYNC9;
        stop2 = 1'b1;
        tx_frame(9'h1a6, 12, BL, 2, frm(9'h1a6, 9));
        mode = SSC_M_WAKE;
        stop2 = 1'b0;
        tx_frame(9'h133, 11, BL, 2, frm(9'h133, 9));
        mode = SSC_M_ASYNC8;
        parity_en = 1'b1;
        for (int o = 0; o < 2; o++) begin
            parity_odd = o[0];
            tx_frame(9'h107, 11, BL, 3, frm({(^8'h07) ^ o[0], 8'h07}, 9));
        end
        $display("test transmit done");
        parity_en = 1'b0;
        frame_chk_en = 1'b1;
        overrun_chk_en = 1'b1;
        rx_frame(frm(9'h03c, 8), 10, 9'h03c, 3'h0);
        rx_frame(frm(9'h0c3, 8), 10, 9'h0c3, 3'h4);
        clr();
        rx_frame(frm(9'h055, 8) & ~12'h200, 10, 9'h055, 3'h2);
        // A low stop bit reads as a fresh start; let that phantom char finish first
        repeat (12 * BL) @(negedge clock);
        clr();
        parity_en = 1'b1;
        for (int o = 0; o < 2; o++) begin
            parity_odd = o[0];
            rx_frame(frm(9'h007, 9), 11, 9'h007, {2'h0, ~o[0]});
            clr();
        end
        parity_en = 1'b0;
        mode = SSC_M_WAKE;
        i_peer.send(frm(9'h011, 9), 11, BL);
        repeat (2) @(negedge clock);
        check(rx_full, 1'b0);
        rx_frame(frm(9'h1a2, 9), 11, 9'h1a2, 3'h0);
        clr();
        $display("test receive done");
        mode = SSC_M_ASYNC8;
        loopback = 1'b1;
        send_tx(9'h0e1);
        wait_irq(1);
        check(rx_data, 9'h0e1);
        wait_irq(0);
        clr();
        loopback = 1'b0;
        mode = SSC_M_SYNC;
        fork
            i_peer.shift(8'hff, BL, sb);
            begin
                send_tx(9'h03c);
                repeat (2) @(negedge clock);
                check(serial_data_oe_n, 1'b0);
                wait_irq(0);
            end
        join
        check(sb, 8'h3c);
        check(serial_data_oe_n, 1'b1);
        fork
            i_peer.shift(8'h96, BL, sb);
            begin
                pulse(sync_rx_start);
                wait_irq(1);
            end
        join
        check(rx_data, 9'h096);
        clr();
        loopback = 1'b1;
        send_tx(9'h05a);
        wait_irq(1);
        check(rx_data, 9'h05a);
        repeat (BL) @(negedge clock);
        $display("test sync done");
        test_done();
    end
endmodule : tb
`default_nettype wire
